/* File: verilog/rmcfa_core.v */
// Purpose: management command handler, restart policy, fault and alert
// Assumes: commands arrive as writes to the command register
// Notes:   status pins and address strap are synchronised before use
`timescale 1ns/10ps
`include "rmcfa_map.vh"

// Contract
// [R1] auto-restart default; restart command restores it
// [R2] overvoltage: three restarts, 1 s delay, 1 min
// [R3] three failures latch off; else window restarts
// [R4] isolation test reports result, not internal fault
// [R5] host checks redundancy, waits 30 s
// [R6] input read: voltage minus 75 V, power
// [R7] firmware bytes primary, processor, bus controller
// [R8] run timer counts operating hours always
// [R9] fan set: larger of host and internal
// [R10] fan normal cancels override, no data
// [R11] fan read: percent, rpm, absent fan zero
// [R12] unsupported command or data raises alert
// [R13] status follows latest monitored event
// [R14] external conditions never assert fault or alarm
// [R15] input led blinks out of range, off absent
// [R16] alert on power-up, hot insertion, not back-bias
// [R17] status change alerts; clear faults does not
// [R18] host reads status to clear alert
// [R19] default address for 15 s after insertion
// [R20] host waits 15 s after presence
// [R21] host judges fan speed spread
// [R22] host keeps units off 20 to 30 s
// [R23] restart after latch clears alarms, flags success
module rmcfa_core #(
   parameter SEC_CYCLES = `RM_CLK_HZ,
   parameter HOURS_W = 17,
   parameter [HOURS_W-1:0] HOURS_INIT = 0,
   parameter [23:0] FW_REV = 24'h000000,
   parameter NFANS = 3
) (
   input wire core_clk,
   input wire sys_rst,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [`RM_SY_W-1:0] pins_async,
   input wire [2:0] addr_strap,
   input wire [8:0] vin_volts,
   input wire [15:0] pin_watts,
   input wire [7:0] fan_req_pct,
   input wire [NFANS-1:0] fan_present,
   input wire [NFANS*16-1:0] fan_rpm,
   output reg out_en,
   output reg iso_start,
   output reg [7:0] fan_duty,
   output reg fault_pin,
   output reg input_led,
   output reg smb_alert_o,
   output reg smb_alert_oe,
   output reg [2:0] bus_addr
);
   localparam ST_RUN = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_TRY = 2'h2;
   localparam ST_LATCH = 2'h3;
   localparam integer WIN_S = `RM_OV_WINDOW_S;

   // ==========================================================
   // pin synchronisers
   reg [`RM_SY_W-1:0] sy_a;
   reg [`RM_SY_W-1:0] sy;
   reg [`RM_SY_W-1:0] sy_d;
   reg [2:0] strap_a;
   reg [2:0] strap_s;
   genvar g;
   generate
      for (g = 0; g < `RM_SY_W; g = g + 1) begin : gsync
         always @(posedge core_clk) begin
            if (sys_rst) begin
               sy_a[g] <= 1'b0;
               sy[g] <= 1'b0;
               sy_d[g] <= 1'b0;
            end else begin
               sy_a[g] <= pins_async[g];
               sy[g] <= sy_a[g];
               sy_d[g] <= sy[g];
            end
         end
      end
   endgenerate
   always @(posedge core_clk) begin
      if (sys_rst) begin
         strap_a <= 3'h0;
         strap_s <= 3'h0;
      end else begin
         strap_a <= addr_strap;
         strap_s <= strap_a;
      end
   end
   wire rise_ov = sy[`RM_SY_OV] & ~sy_d[`RM_SY_OV];
   wire rise_oc = sy[`RM_SY_OC] & ~sy_d[`RM_SY_OC];
   wire rise_ot = sy[`RM_SY_OT] & ~sy_d[`RM_SY_OT];
   wire trip = rise_ov | rise_oc | rise_ot;
   wire inserted = sy[`RM_SY_PRESENT] & ~sy_d[`RM_SY_PRESENT];

   // ==========================================================
   // one-second tick; the divider is long, so it is a parameter
   reg [31:0] div;
   reg sec;
   reg blink;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         div <= 32'h0;
         sec <= 1'b0;
         blink <= 1'b0;
      end else if (div == SEC_CYCLES - 1) begin
         div <= 32'h0;
         sec <= 1'b1;
         blink <= ~blink;
      end else begin
         div <= div + 32'h1;
         sec <= 1'b0;
      end
   end

   // ==========================================================
   // wishbone slave, ack one cycle after the strobe
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire cmd_wr = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `RM_REG_CMD);
   wire stat_rd = req & ~wb_we_i & (wb_adr_i == `RM_REG_STATUS);
   wire [7:0] code = wb_dat_i[`RM_CMD_CODE];
   wire [7:0] cdata = wb_dat_i[`RM_CMD_DATA];
   wire has_data = wb_dat_i[`RM_CMD_HAS_DATA];
   wire c_clear = cmd_wr & (code == `RM_CMD_CLEAR_FAULTS);
   wire c_auto = cmd_wr & (code == `RM_CMD_AUTO_RESTART);
   wire c_iso = cmd_wr & (code == `RM_CMD_ISO_TEST);
   wire c_fset = cmd_wr & (code == `RM_CMD_FAN_SET);
   wire c_fnorm = cmd_wr & (code == `RM_CMD_FAN_NORMAL);
   wire known = (code == `RM_CMD_CLEAR_FAULTS) |
      (code == `RM_CMD_AUTO_RESTART) | (code == `RM_CMD_ISO_TEST) |
      (code == `RM_CMD_READ_INPUT) | (code == `RM_CMD_READ_FWREV) |
      (code == `RM_CMD_READ_TIMER) | (code == `RM_CMD_FAN_NORMAL) |
      (code == `RM_CMD_READ_FAN) | (code == `RM_CMD_CLK_HOLD_TEST) |
      (code == `RM_CMD_FAN_SET);
   wire bad_data = (code == `RM_CMD_FAN_SET) &
      (~has_data | (cdata > `RM_FAN_MAX_PCT));
   wire c_bad = cmd_wr & (~known | bad_data); // R12

   // ==========================================================
   // restart policy
   reg [1:0] st;
   reg [1:0] ov_cnt;
   reg [5:0] win;
   reg [3:0] dly;
   reg from_latch;
   reg restart_ok;
   reg al_ov;
   reg al_oc;
   reg al_ot;
   reg cmd_err;
   wire clr_alarms = c_clear | (st == ST_TRY & from_latch &
      sy[`RM_SY_OUT_GOOD]);
   always @(posedge core_clk) begin
      if (sys_rst) begin
         st <= ST_TRY;
         out_en <= 1'b1;
         ov_cnt <= 2'h0;
         win <= 6'h0;
         dly <= 4'h0;
         from_latch <= 1'b0;
         restart_ok <= 1'b0;
      end else begin
         // window runs while overvoltage shutdowns are counted
         if (ov_cnt != 2'h0 && sec) begin
            if (win == WIN_S[5:0] - 6'h1) begin
               win <= 6'h0;
               ov_cnt <= 2'h0; // R3
            end else begin
               win <= win + 6'h1; // R2
            end
         end
         if (c_clear)
            restart_ok <= 1'b0;
         case (st)
            ST_RUN, ST_TRY: begin
               if (trip) begin
                  out_en <= 1'b0;
                  from_latch <= 1'b0;
                  dly <= `RM_RESTART_DLY_S; // R2
                  if (rise_ov && ov_cnt == `RM_OV_MAX_TRIES) begin
                     st <= ST_LATCH; // R3
                  end else begin
                     st <= ST_DELAY; // R1
                     if (rise_ov)
                        ov_cnt <= ov_cnt + 2'h1; // R2
                  end
               end else if (st == ST_TRY && sy[`RM_SY_OUT_GOOD]) begin
                  st <= ST_RUN;
                  if (from_latch)
                     restart_ok <= 1'b1; // R23
                  from_latch <= 1'b0;
               end
            end
            ST_DELAY: begin
               if (c_auto) begin
                  ov_cnt <= 2'h0; // R1
               end
               if (sec) begin
                  // the tick is free running: one spare tick keeps the
                  // pause at one full second or more
                  if (dly == 4'h0) begin
                     st <= ST_TRY;
                     out_en <= 1'b1;
                  end else begin
                     dly <= dly - 4'h1;
                  end
               end
            end
            ST_LATCH: begin
               if (c_auto) begin
                  st <= ST_TRY; // R1
                  out_en <= 1'b1;
                  ov_cnt <= 2'h0;
                  win <= 6'h0;
                  from_latch <= 1'b1;
               end
            end
            default: st <= ST_RUN;
         endcase
      end
   end

   // ==========================================================
   // alarms; a new event wins over a clear in the same cycle
   reg iso_ok;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         al_ov <= 1'b0;
         al_oc <= 1'b0;
         al_ot <= 1'b0;
         cmd_err <= 1'b0;
         iso_ok <= 1'b0;
         iso_start <= 1'b0;
      end else begin
         al_ov <= rise_ov | (al_ov & ~clr_alarms); // R23
         al_oc <= rise_oc | (al_oc & ~clr_alarms);
         al_ot <= rise_ot | (al_ot & ~clr_alarms);
         cmd_err <= c_bad | (cmd_err & ~clr_alarms); // R12
         iso_start <= c_iso; // R4
         if (c_iso)
            iso_ok <= 1'b0;
         else if (sy[`RM_SY_ISO_DONE] & ~sy_d[`RM_SY_ISO_DONE])
            iso_ok <= sy[`RM_SY_ISO_PASS]; // R4
      end
   end
   // live status: latest monitored state, no snapshot
   wire ext_fault = ~sy[`RM_SY_VIN_OK] | al_oc; // R14
   wire int_fault = sy[`RM_SY_INT_FAULT]; // R14
   wire [15:0] status = {3'h0, al_ot, al_oc, al_ov, ~sy[`RM_SY_VIN_OK],
      1'b0, cmd_err, restart_ok, st == ST_LATCH, ~out_en, ext_fault,
      int_fault, iso_ok, out_en}; // R13

   // ==========================================================
   // alert generation
   reg [15:0] stat_d;
   reg clr_d;
   reg [1:0] pu_cnt;
   reg [3:0] settle;
   reg settled;
   // synchronisers still fill just after reset: their false edges and
   // status steps must not alert, or back-bias could never stay quiet
   wire sy_ready = (pu_cnt == `RM_SYNC_SETTLE);
   wire stat_chg = (status != stat_d) & ~clr_d & sy_ready; // R17
   wire pu_evt = (pu_cnt == `RM_SYNC_SETTLE - 2'h1) &
      ~sy[`RM_SY_BACKBIAS]; // R16
   always @(posedge core_clk) begin
      if (sys_rst) begin
         stat_d <= 16'h0;
         clr_d <= 1'b0;
         pu_cnt <= 2'h0;
         smb_alert_o <= 1'b0;
         smb_alert_oe <= 1'b0;
         fault_pin <= 1'b0;
      end else begin
         stat_d <= status;
         clr_d <= c_clear; // R17
         if (pu_cnt != `RM_SYNC_SETTLE)
            pu_cnt <= pu_cnt + 2'h1;
         smb_alert_o <= 1'b0;
         if (stat_chg | pu_evt | (inserted & sy_ready) | c_bad) // R12 R16 R17
            smb_alert_oe <= 1'b1;
         else if (stat_rd)
            smb_alert_oe <= 1'b0; // R18
         fault_pin <= int_fault; // R14
      end
   end

   // ==========================================================
   // address settling after insertion
   always @(posedge core_clk) begin
      if (sys_rst) begin
         settle <= 4'h0;
         settled <= 1'b0;
         bus_addr <= `RM_DEFAULT_ADDR;
      end else if (inserted | ~sy[`RM_SY_PRESENT]) begin
         settle <= 4'h0;
         settled <= 1'b0;
         bus_addr <= `RM_DEFAULT_ADDR; // R19
      end else if (!settled && sec) begin
         if (settle == `RM_ADDR_SETTLE_S - 1) begin
            settled <= 1'b1;
            bus_addr <= strap_s; // R19
         end else begin
            settle <= settle + 4'h1;
         end
      end
   end

   // ==========================================================
   // run timer, leds, fan
   reg [11:0] hsec;
   reg [HOURS_W-1:0] hours;
   reg fan_ovr;
   reg [7:0] fan_pct;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         hsec <= 12'h0;
         hours <= HOURS_INIT;
         input_led <= 1'b0;
         fan_ovr <= 1'b0;
         fan_pct <= 8'h0;
         fan_duty <= 8'h0;
      end else begin
         if (sec) begin
            if (hsec == `RM_HOUR_S - 1) begin
               hsec <= 12'h0;
               hours <= hours + 1'b1; // R8
            end else begin
               hsec <= hsec + 12'h1;
            end
         end
         if (!sy[`RM_SY_VIN_PRES])
            input_led <= 1'b0; // R15
         else if (!sy[`RM_SY_VIN_OK])
            input_led <= blink; // R15
         else
            input_led <= 1'b1;
         if (c_fset && !bad_data) begin
            fan_ovr <= 1'b1;
            fan_pct <= cdata; // R9
         end else if (c_fnorm) begin
            fan_ovr <= 1'b0; // R10
         end
         if (fan_ovr && fan_pct > fan_req_pct)
            fan_duty <= fan_pct; // R9
         else
            fan_duty <= fan_req_pct;
      end
   end

   // ==========================================================
   // register read mux
   // readings above the byte range saturate instead of wrapping
   wire [8:0] vin_diff = vin_volts - `RM_VIN_OFFSET_V;
   wire [7:0] vin_rep = (vin_volts <= `RM_VIN_OFFSET_V) ? 8'h0 :
      (vin_diff[8] ? 8'hff : vin_diff[7:0]); // R6
   wire [NFANS*16-1:0] rpm_q;
   generate
      for (g = 0; g < NFANS; g = g + 1) begin : gfan
         assign rpm_q[g*16 +: 16] = fan_present[g] ?
            fan_rpm[g*16 +: 16] : 16'h0; // R11
      end
   endgenerate
   reg [31:0] rd;
   integer i;
   always @* begin
      rd = 32'h0;
      case (wb_adr_i)
         `RM_REG_STATUS: rd = {16'h0, status};
         `RM_REG_INPUT: rd = {8'h0, pin_watts, vin_rep}; // R6
         `RM_REG_FWREV: rd = {8'h0, FW_REV}; // R7
         `RM_REG_TIMER: rd = {{(32-HOURS_W){1'b0}}, hours}; // R8
         `RM_REG_FAN: rd = {24'h0, fan_duty}; // R11
         `RM_REG_ADDR: rd = {28'h0, settled, bus_addr};
         default: begin
            for (i = 0; i < NFANS; i = i + 1)
               if (wb_adr_i == `RM_REG_FAN_RPM0 + 4 * i)
                  rd = {16'h0, rpm_q[i*16 +: 16]};
         end
      endcase
   end
   always @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req & ~wb_we_i) ? rd : 32'h0;
      end
   end
endmodule

/* File: include/rmcfa_map.vh */
// Purpose: constants of the rectifier management command and alert block
// Assumes: 10 MHz core clock, 32-bit classic Wishbone register access
// Notes:   definitions only
`ifndef RMCFA_MAP_VH
`define RMCFA_MAP_VH
// ==========================================================
// timing, in the units stated
`define RM_CLK_HZ 10000000
`define RM_RESTART_DLY_S 4'h1
`define RM_OV_WINDOW_S 60
`define RM_OV_MAX_TRIES 3
`define RM_ADDR_SETTLE_S 15
`define RM_HOUR_S 3600
`define RM_SYNC_SETTLE 2'h3
// ==========================================================
// data conventions
`define RM_VIN_OFFSET_V 9'h04b
`define RM_FAN_MAX_PCT 8'h64
`define RM_DEFAULT_ADDR 3'h0
// ==========================================================
// command codes
`define RM_CMD_CLEAR_FAULTS 8'h03
`define RM_CMD_AUTO_RESTART 8'hd9
`define RM_CMD_ISO_TEST 8'hda
`define RM_CMD_READ_INPUT 8'hdc
`define RM_CMD_READ_FWREV 8'hdd
`define RM_CMD_READ_TIMER 8'hde
`define RM_CMD_FAN_SET 8'hdf
`define RM_CMD_FAN_NORMAL 8'he0
`define RM_CMD_READ_FAN 8'he1
`define RM_CMD_CLK_HOLD_TEST 8'he2
// ==========================================================
// register byte offsets
`define RM_REG_CMD 8'h00
`define RM_REG_STATUS 8'h04
`define RM_REG_INPUT 8'h08
`define RM_REG_FWREV 8'h0c
`define RM_REG_TIMER 8'h10
`define RM_REG_FAN 8'h14
`define RM_REG_FAN_RPM0 8'h18
`define RM_REG_ADDR 8'h24
// ==========================================================
// command register fields
`define RM_CMD_CODE 7:0
`define RM_CMD_DATA 15:8
`define RM_CMD_HAS_DATA 16
// ==========================================================
// synchronised pin indices
`define RM_SY_PRESENT 0
`define RM_SY_OV 1
`define RM_SY_OC 2
`define RM_SY_OT 3
`define RM_SY_VIN_OK 4
`define RM_SY_VIN_PRES 5
`define RM_SY_BACKBIAS 6
`define RM_SY_ISO_DONE 7
`define RM_SY_ISO_PASS 8
`define RM_SY_OUT_GOOD 9
`define RM_SY_INT_FAULT 10
`define RM_SY_W 11
`endif

/* File: tb/rmcfa_core_sva.sv */
// Purpose: protocol and behaviour checks on the command and alert block
// Assumes: bench writes commands with all byte lanes enabled, save one write with lane 0 off
// Notes:   sync latency of the pins taken as at most three cycles
`timescale 1ns/10ps
module rmcfa_core_sva (
   input wire core_clk,
   input wire sys_rst,
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire [10:0] pins_async,
   input wire [7:0] fan_req_pct,
   input wire out_en,
   input wire iso_start,
   input wire [7:0] fan_duty,
   input wire fault_pin,
   input wire input_led,
   input wire smb_alert_o,
   input wire smb_alert_oe,
   input wire [2:0] bus_addr
);
   // ==========================================================
   // helpers
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire cmd = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00);
   wire [7:0] code = wb_dat_i[7:0];
   wire fan_ok = wb_dat_i[16] & (wb_dat_i[15:8] <= 8'h64);
   wire known = (code == 8'h03) | (code == 8'hdf & fan_ok) |
      (code >= 8'hd9 && code <= 8'he2 && code != 8'hdb && code != 8'hdf);
   reg req_d = 1'b0;
   reg [7:0] req_d1 = 8'h00;
   reg [7:0] req_d2 = 8'h00;
   reg [3:0] flt_age = 4'hf;
   reg [1:0] up = 2'h0;
   always @(posedge core_clk) begin
      req_d <= req;
      req_d1 <= fan_req_pct;
      req_d2 <= req_d1;
      if (pins_async[10])
         flt_age <= 4'h0;
      else if (flt_age != 4'hf)
         flt_age <= flt_age + 4'h1;
      if (sys_rst)
         up <= 2'h0;
      else if (up != 2'h3)
         up <= up + 2'h1;
   end
   // ==========================================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence one_pulse(s);
      s ##1 !s;
   endsequence
   sequence vin_gone;
      (!pins_async[5]) [*6];
   endsequence
   ack_one_cycle_a: assert property (req |=> one_pulse(wb_ack_o))
      else $error("ack not a single pulse after request");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> req_d)
      else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   alert_drive_a: assert property (smb_alert_o == 1'b0)
      else $error("alert line driven high");
   bad_cmd_alert_a: assert property (cmd && !known |-> ##[1:3] smb_alert_oe)
      else $error("no alert after bad command");
   iso_pulse_a: assert property (cmd && code == 8'hda |-> ##[1:3] one_pulse(iso_start))
      else $error("isolation start pulse missing");
   ov_shut_a: assert property ($rose(pins_async[1]) |-> ##[1:5] !out_en)
      else $error("no shutdown after overvoltage");
   fault_cause_a: assert property ($rose(fault_pin) |-> flt_age < 4'h6)
      else $error("fault pin without internal fault");
   fan_floor_a: assert property (up == 2'h3 && req_d1 == fan_req_pct &&
      req_d2 == fan_req_pct |-> fan_duty >= fan_req_pct)
      else $error("fan duty below internal need");
   addr_default_a: assert property ($rose(pins_async[0]) |->
      ##4 (bus_addr == 3'h0) [*8])
      else $error("address not default after insertion");
   led_off_a: assert property (vin_gone |-> !input_led)
      else $error("input led lit with input absent");
endmodule

/* File: tb/rmcfa_plant.sv */
// Purpose: power stage seen by the block: isolation test and output good
// Assumes: isolation result set by the bench before the test starts
// Notes:   result line toggles when not valid, so no stale value passes
`timescale 1ns/10ps
module rmcfa_plant #(
   parameter DLY = 10
) (
   input wire core_clk,
   input wire iso_start,
   input wire out_en,
   input wire pass_cfg,
   output reg iso_done,
   output reg iso_pass,
   output reg out_good
);
   integer cnt = 0;
   initial begin
      iso_done = 1'b0;
      iso_pass = 1'b0;
      out_good = 1'b0;
   end
   always @(posedge core_clk) begin
      out_good <= out_en;
      if (iso_start)
         cnt <= DLY + 4;
      else if (cnt > 0)
         cnt <= cnt - 1;
      iso_done <= (cnt >= 1 && cnt <= 4);
      iso_pass <= (cnt >= 1 && cnt <= 6) ? pass_cfg : ~iso_pass;
   end
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench of the management command block
// Assumes: one second shortened to SEC core clock cycles
// Notes:   plant model answers the isolation test
`timescale 1ns/10ps
module tb;
   localparam SEC = 20;
   reg core_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [7:0] adr = 8'h00;
   reg [31:0] wdat = 32'h0;
   reg we = 1'b0;
   reg cyc = 1'b0;
   reg [10:0] pins = 11'h031;
   reg pass_cfg = 1'b0;
   reg [3:0] sel = 4'hf;
   reg [7:0] fan_req = 8'h20;
   wire [31:0] rdat;
   wire ack, out_en, iso_start, fault_pin, input_led, al_o, al_oe;
   wire iso_done, iso_pass, good;
   wire [7:0] fan_duty;
   wire [2:0] bus_addr;
   wire [10:0] pa = {pins[10], good, iso_pass, iso_done, pins[6:0]};
   integer errors = 0;
   integer checked = 0;
   integer i;
   reg [31:0] v;
   reg [71:0] rows [0:8];
   always #50 core_clk = ~core_clk;
   rmcfa_core #(.SEC_CYCLES(SEC), .FW_REV(24'h002114)) u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(adr),
      .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .pins_async(pa),
      .addr_strap(3'h5), .vin_volts(9'h0e6), .pin_watts(16'h1234),
      .fan_req_pct(fan_req), .fan_present(3'h3),
      .fan_rpm(48'h0777_0abc_0bb8), .out_en(out_en),
      .iso_start(iso_start), .fan_duty(fan_duty), .fault_pin(fault_pin),
      .input_led(input_led), .smb_alert_o(al_o), .smb_alert_oe(al_oe),
      .bus_addr(bus_addr));
   rmcfa_plant u_plant (.core_clk(core_clk), .iso_start(iso_start),
      .out_en(out_en), .pass_cfg(pass_cfg), .iso_done(iso_done),
      .iso_pass(iso_pass), .out_good(good));
   // ==========================================================
   // tasks
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wb(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge core_clk);
         adr <= a;
         we <= w;
         wdat <= d;
         cyc <= 1'b1;
         @(posedge core_clk);
         // only the watchdog ends a wait for ack
         while (ack !== 1'b1)
            @(posedge core_clk);
         v = rdat;
         cyc <= 1'b0;
         we <= 1'b0;
      end
   endtask
   task ov_hit;
      begin
         pins[1] <= 1'b1;
         repeat (5) @(posedge core_clk);
         pins[1] <= 1'b0;
         repeat (2 * SEC + 5) @(posedge core_clk);
      end
   endtask
   task conclude;
      begin
         $display("checked %0d errors %0d", checked, errors);
         if (errors == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   initial begin
      repeat (10000) @(posedge core_clk);
      errors = errors + 1;
      conclude;
   end
   // ==========================================================
   // sequence: command word, read address, expected read
   initial begin
      rows[0] = {32'h0, 8'h08, 32'h0012349b};
      rows[1] = {32'h0, 8'h0c, 32'h00002114};
      rows[2] = {32'h0, 8'h18, 32'h00000bb8};
      rows[3] = {32'h0, 8'h1c, 32'h00000abc};
      rows[4] = {32'h0, 8'h20, 32'h0};
      rows[5] = {32'h0, 8'h3c, 32'h0};
      rows[6] = {32'h000150df, 8'h14, 32'h50};
      rows[7] = {32'h000164df, 8'h14, 32'h64};
      rows[8] = {32'h000000e0, 8'h14, 32'h20};
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk(al_oe, 1);
      wb(8'h04, 0, 0);
      @(posedge core_clk);
      chk(al_oe, 0);
      $display("reset done");
      for (i = 0; i < 9; i = i + 1) begin
         if (rows[i][71:40] != 32'h0)
            wb(8'h00, 1, rows[i][71:40]);
         wb(rows[i][39:32], 0, 0);
         chk(v, rows[i][31:0]);
      end
      $display("table done");
      // internal need above the override wins
      wb(8'h00, 1, 32'h000150df);
      fan_req <= 8'h60;
      wb(8'h14, 0, 0);
      chk(v, 32'h60);
      fan_req <= 8'h20;
      wb(8'h00, 1, 32'he0);
      // a command without byte lane 0 is not taken
      sel <= 4'he;
      wb(8'h00, 1, 32'h55);
      sel <= 4'hf;
      wb(8'h04, 0, 0);
      chk(v[7], 0);
      wb(8'h00, 1, 32'h55);
      repeat (3) @(posedge core_clk);
      chk(al_oe, 1);
      wb(8'h04, 0, 0);
      chk(v[7], 1);
      // out of range percentage must not reach the fan
      wb(8'h00, 1, 32'h000165df);
      repeat (3) @(posedge core_clk);
      chk({al_oe, fan_duty}, 9'h120);
      wb(8'h04, 0, 0);
      wb(8'h00, 1, 32'h03);
      repeat (3) @(posedge core_clk);
      chk(al_oe, 0);
      wb(8'h04, 0, 0);
      chk(v[7], 0);
      $display("command errors done");
      for (i = 0; i < 2; i = i + 1) begin
         pass_cfg <= i[0];
         wb(8'h00, 1, 32'hda);
         repeat (30 * SEC) @(posedge core_clk);
         wb(8'h04, 0, 0);
         chk({v[2:1], fault_pin}, {1'b0, i[0], 1'b0});
      end
      $display("isolation done");
      for (i = 0; i < 4; i = i + 1) begin
         ov_hit;
         chk(out_en, i < 3);
      end
      wb(8'h04, 0, 0);
      chk(v[5], 1);
      repeat (20 * SEC) @(posedge core_clk);
      wb(8'h00, 1, 32'hd9);
      repeat (10) @(posedge core_clk);
      chk(out_en, 1);
      wb(8'h04, 0, 0);
      chk({v[10], v[6:5]}, 3'b010);
      // two hits, a full window of quiet, then three more stay running
      ov_hit;
      ov_hit;
      repeat (61 * SEC) @(posedge core_clk);
      for (i = 0; i < 3; i = i + 1)
         ov_hit;
      chk(out_en, 1);
      $display("restart done");
      pins[2] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(fault_pin, 0);
      pins[2] <= 1'b0;
      pins[10] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(fault_pin, 1);
      pins[10] <= 1'b0;
      pins[4] <= 1'b0;
      v = 0;
      repeat (100) begin
         @(posedge core_clk);
         if (input_led === 1'b1)
            v[1] = 1'b1;
         else if (input_led === 1'b0)
            v[0] = 1'b1;
      end
      chk(v[1:0], 2'h3);
      pins[5] <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk(input_led, 0);
      $display("faults done");
      pins[0] <= 1'b0;
      repeat (4) @(posedge core_clk);
      pins[0] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(bus_addr, 0);
      repeat (15 * SEC + 10) @(posedge core_clk);
      wb(8'h24, 0, 0);
      chk(v, 32'hd);
      $display("address done");
      // mid-run reset while back-biased: reset values, then no alert
      pins[6] <= 1'b1;
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk({out_en, al_oe, fan_duty, bus_addr}, 13'h1000);
      sys_rst <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk(al_oe, 0);
      $display("back-bias done");
      conclude;
   end
endmodule
bind rmcfa_core rmcfa_core_sva u_sva (.core_clk(core_clk),
   .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pins_async(pins_async), .fan_req_pct(fan_req_pct), .out_en(out_en),
   .iso_start(iso_start), .fan_duty(fan_duty), .fault_pin(fault_pin),
   .input_led(input_led), .smb_alert_o(smb_alert_o),
   .smb_alert_oe(smb_alert_oe), .bus_addr(bus_addr));
